// *** verilog/scm_map.vh ***
`ifndef SCM_MAP_VH
`define SCM_MAP_VH
// system clock selector codes
`define SCM_SEL_DIV1      3'h0
`define SCM_SEL_SLOW      3'h7
`define SCM_SEL_RST       3'h0
`define SCM_FAST_EN_RST   1'b1
// oscillator rates and stabilisation time
`define SCM_CLK_MHZ       125
`define SCM_FAST_OSC_KHZ  8000
`define SCM_SLOW_OSC_KHZ  32
`define SCM_FAST_STAB_US  20
`define SCM_FAST_STAB_CYC (`SCM_FAST_STAB_US * `SCM_CLK_MHZ)
// fast half period: 125000/8000/2 = 7.8 -> 7 cycles (round down)
`define SCM_FAST_HALF_CYC ((`SCM_CLK_MHZ * 1000) / (`SCM_FAST_OSC_KHZ * 2))
`define SCM_SLOW_HALF_CYC ((`SCM_CLK_MHZ * 1000) / (`SCM_SLOW_OSC_KHZ * 2))
// operating mode codes
`define SCM_MODE_FAST     3'h0
`define SCM_MODE_SLOW     3'h1
`define SCM_MODE_SLEEP    3'h2
`define SCM_MODE_IDLE_S   3'h3
`define SCM_MODE_IDLE_B   3'h4
`define SCM_MODE_IDLE_F   3'h5
`endif

// *** verilog/scm_osc_model.v ***
`include "scm_map.vh"
// on-chip rc oscillator stand-in: enable-pulse generator from the system clock
module scm_osc_model #(
    parameter HALF_CYC = 7,
    parameter STAB_CYC = 1
) (
    input  wire mclk_i,
    input  wire rst_i,
    input  wire run_i,
    output wire tick_o,
    output wire stable_o
);
    reg [15:0] half_cnt_reg;
    reg [15:0] stab_cnt_reg;
    reg        stable_reg;
    reg        phase_reg;

    always @(posedge mclk_i)
    begin
        if (rst_i || !run_i)
        begin
            half_cnt_reg <= 16'h0000;
            stab_cnt_reg <= 16'h0000;
            stable_reg   <= 1'b0;
            phase_reg    <= 1'b0;
        end
        else
        begin
            if (half_cnt_reg == HALF_CYC[15:0] - 16'h0001)
            begin
                half_cnt_reg <= 16'h0000;
                phase_reg    <= ~phase_reg;
            end
            else
                half_cnt_reg <= half_cnt_reg + 16'h0001;
            if (stab_cnt_reg == STAB_CYC[15:0] - 16'h0001)
                stable_reg <= 1'b1;
            else if (!stable_reg)
                stab_cnt_reg <= stab_cnt_reg + 16'h0001;
        end
    end

    // one tick per full oscillator period
    assign tick_o   = run_i && phase_reg && (half_cnt_reg == HALF_CYC[15:0] - 16'h0001);
    assign stable_o = stable_reg;
endmodule

// *** verilog/scm_sysclk_ctrl.v ***
`include "scm_map.vh"
// Contract
// - fast clock from internal 8MHz oscillator
// - slow clock from internal 32kHz oscillator
// - fast run divides fast clock 1..64
// - codes 000-110 divide, 111 selects slow
// - selector change allowed while running
// - fast run keeps all clocks running
// - code 111 runs processor from slow
// - slow run fast osc follows enable bit
// - six modes: two run, four power-down
// - halt, both keeps low: sleep
// - sleep keeps slow rc only for watchdog
// - halt, slow keep only: idle slow
// - halt, both keeps high: idle both
// - halt, fast keep only: idle fast
// - oscillators feed watchdog and time base
// - stable flag clears then sets on enable
module scm_sysclk_ctrl #(
    parameter FAST_STAB_CYC = `SCM_FAST_STAB_CYC
) (
    input  wire       mclk_i,
    input  wire       rst_i,
    input  wire [2:0] sys_clk_select_i,
    input  wire       fast_osc_enable_i,
    input  wire       fast_osc_idle_keep_i,
    input  wire       slow_osc_idle_keep_i,
    input  wire       halt_i,
    input  wire       wake_i,
    input  wire       wdt_enable_i,
    output wire       cpu_clk_en_o,
    output wire       sys_clk_en_o,
    output wire       fast_clk_en_o,
    output wire       slow_clk_en_o,
    output wire       slow_rc_clk_en_o,
    output wire       fast_osc_run_o,
    output wire       slow_osc_run_o,
    output reg        fast_osc_stable_flag_o,
    output reg  [2:0] active_select_o,
    output reg  [2:0] op_mode_o
);
    localparam ST_RUN  = 1'b0;
    localparam ST_DOWN = 1'b1;

    reg        state_reg;
    reg        state_next;
    reg        fast_keep_reg;
    reg        slow_keep_reg;
    reg  [2:0] sel_reg;
    reg  [5:0] div_cnt_reg;
    reg  [5:0] div_cnt_next;
    reg        div_tick;
    wire       fast_tick;
    wire       slow_tick;
    wire       fast_stable;
    wire       slow_stable;
    wire       fast_run;
    wire       slow_run;
    wire       sel_slow;
    wire       src_tick;
    wire       down;

    assign down     = (state_reg == ST_DOWN);
    assign sel_slow = (sel_reg == `SCM_SEL_SLOW);

    // fast oscillator: always on in fast run, enable bit in slow run, idle keep bit in power-down
    // a pending fast code also starts it, else the switch back would wait forever
    assign fast_run = down ? fast_keep_reg :
                      (fast_osc_enable_i || !sel_slow || sys_clk_select_i != `SCM_SEL_SLOW);
    // slow rc stops only in sleep without watchdog; idle fast gates the slow clock instead
    assign slow_run = !down || fast_keep_reg || slow_keep_reg || wdt_enable_i;

    scm_osc_model #(
        .HALF_CYC (`SCM_FAST_HALF_CYC),
        .STAB_CYC (FAST_STAB_CYC)
    ) u_fast_osc (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .run_i    (fast_run),
        .tick_o   (fast_tick),
        .stable_o (fast_stable)
    );

    scm_osc_model #(
        .HALF_CYC (`SCM_SLOW_HALF_CYC),
        .STAB_CYC (1)
    ) u_slow_osc (
        .mclk_i   (mclk_i),
        .rst_i    (rst_i),
        .run_i    (slow_run),
        .tick_o   (slow_tick),
        .stable_o (slow_stable)
    );

    // power-down sequencing; keep bits are latched at the halt
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
                if (halt_i)
                    state_next = ST_DOWN;
            ST_DOWN:
                if (wake_i)
                    state_next = ST_RUN;
            default:
                state_next = ST_RUN;
        endcase
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_reg     <= ST_RUN;
            fast_keep_reg <= 1'b0;
            slow_keep_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            if (!down && halt_i)
            begin
                fast_keep_reg <= fast_osc_idle_keep_i;
                slow_keep_reg <= slow_osc_idle_keep_i;
            end
        end
    end

    // selector takes effect only when the new source is stable; a change to a fast code
    // also waits for a tick of the current source, while a change to slow code 111 does not wait for one
    always @(posedge mclk_i)
    begin
        if (rst_i)
            sel_reg <= `SCM_SEL_RST;
        else if (sys_clk_select_i != sel_reg && !down)
        begin
            if (sys_clk_select_i == `SCM_SEL_SLOW)
            begin
                if (slow_stable && (fast_tick || !fast_stable || !sel_slow))
                    sel_reg <= sys_clk_select_i;
            end
            else if (fast_stable && (sel_slow ? slow_tick : div_tick))
                sel_reg <= sys_clk_select_i;
        end
    end

    // divide-by-2^n of the fast ticks
    always @*
    begin
        div_cnt_next = div_cnt_reg;
        div_tick     = 1'b0;
        if (fast_tick)
        begin
            div_cnt_next = div_cnt_reg + 6'h01;
            case (sel_reg)
                3'h0:    div_tick = 1'b1;
                3'h1:    div_tick = (div_cnt_reg[0]   == 1'b1);
                3'h2:    div_tick = (div_cnt_reg[1:0] == 2'h3);
                3'h3:    div_tick = (div_cnt_reg[2:0] == 3'h7);
                3'h4:    div_tick = (div_cnt_reg[3:0] == 4'hf);
                3'h5:    div_tick = (div_cnt_reg[4:0] == 5'h1f);
                3'h6:    div_tick = (div_cnt_reg      == 6'h3f);
                default: div_tick = 1'b0;
            endcase
        end
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
            div_cnt_reg <= 6'h00;
        else
            div_cnt_reg <= div_cnt_next;
    end

    assign src_tick = sel_slow ? slow_tick : div_tick;

    // stable flag drops one cycle after the oscillator is stopped
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            fast_osc_stable_flag_o <= 1'b0;
            active_select_o        <= `SCM_SEL_RST;
            op_mode_o              <= `SCM_MODE_FAST;
        end
        else
        begin
            fast_osc_stable_flag_o <= fast_run && fast_stable;
            active_select_o        <= sel_reg;
            if (!down)
                op_mode_o <= sel_slow ? `SCM_MODE_SLOW : `SCM_MODE_FAST;
            else
                case ({fast_keep_reg, slow_keep_reg})
                    2'b00:   op_mode_o <= `SCM_MODE_SLEEP;
                    2'b01:   op_mode_o <= `SCM_MODE_IDLE_S;
                    2'b11:   op_mode_o <= `SCM_MODE_IDLE_B;
                    default: op_mode_o <= `SCM_MODE_IDLE_F;
                endcase
        end
    end

    assign cpu_clk_en_o = !down && src_tick;
    // in idle the system clock runs only while its own source is kept
    assign sys_clk_en_o = src_tick && (!down || (sel_slow ? slow_keep_reg : fast_keep_reg));
    assign fast_clk_en_o    = fast_tick;
    assign slow_clk_en_o    = slow_tick && (!down || slow_keep_reg);
    assign slow_rc_clk_en_o = slow_tick;
    assign fast_osc_run_o   = fast_run;
    assign slow_osc_run_o   = slow_run;
endmodule

// *** tb/scm_sysclk_properties.sv ***
`include "scm_map.vh"
module scm_sysclk_chk (
    input logic       mclk_i,
    input logic       rst_i,
    input logic       halt_i,
    input logic       wake_i,
    input logic       wdt_enable_i,
    input logic       fast_osc_enable_i,
    input logic       fast_osc_idle_keep_i,
    input logic       slow_osc_idle_keep_i,
    input logic       cpu_clk_en_o,
    input logic       slow_clk_en_o,
    input logic       fast_osc_run_o,
    input logic       slow_osc_run_o,
    input logic       fast_osc_stable_flag_o,
    input logic [2:0] active_select_o,
    input logic [2:0] op_mode_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire       fk  = fast_osc_idle_keep_i;
    wire       sk  = slow_osc_idle_keep_i;
    wire       hlt = halt_i && op_mode_o < `SCM_MODE_SLEEP;
    a_halt_sleep: assert property (hlt && !fk && !sk |-> ##[1:2] op_mode_o == `SCM_MODE_SLEEP)
        else $error("sleep entry wrong");
    a_halt_idle_s: assert property (hlt && !fk && sk |-> ##[1:2] op_mode_o == `SCM_MODE_IDLE_S)
        else $error("slow idle entry wrong");
    a_halt_idle_b: assert property (hlt && fk && sk |-> ##[1:2] op_mode_o == `SCM_MODE_IDLE_B)
        else $error("both idle entry wrong");
    a_halt_idle_f: assert property (hlt && fk && !sk |-> ##[1:2] op_mode_o == `SCM_MODE_IDLE_F)
        else $error("fast idle entry wrong");
    a_sleep_clk_off: assert property (op_mode_o == `SCM_MODE_SLEEP && !$past(wake_i)
        |-> !slow_clk_en_o && !cpu_clk_en_o && !fast_osc_run_o) else $error("clock in sleep");
    a_sleep_wdt_rc: assert property (op_mode_o == `SCM_MODE_SLEEP && !$past(wake_i)
        |-> slow_osc_run_o == wdt_enable_i) else $error("slow rc vs watchdog");
    a_fast_all_run: assert property (op_mode_o == `SCM_MODE_FAST && fast_osc_enable_i
        && !$past(halt_i) |-> fast_osc_run_o && slow_osc_run_o) else $error("osc off in fast");
    a_flag_after_run: assert property ($rose(fast_osc_stable_flag_o)
        |-> $past(fast_osc_run_o, 8)) else $error("flag rose too early");
    a_sel_hold_down: assert property (op_mode_o >= `SCM_MODE_SLEEP && !$past(wake_i)
        |=> $stable(active_select_o)) else $error("select moved in power-down");
    c_idle_both: cover property (op_mode_o == `SCM_MODE_IDLE_B);
    c_flag_rise: cover property ($rose(fast_osc_stable_flag_o));
    c_slow_sel: cover property (active_select_o == `SCM_SEL_SLOW);
endmodule
bind scm_sysclk_ctrl scm_sysclk_chk u_chk (.*);

// *** tb/scm_sysclk_ctrl_tb_top.sv ***
`include "scm_map.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module scm_sysclk_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk_i = 0, rst_i = 1, halt_i = 0, wake_i = 0, wdt_enable_i = 0;
    logic       fast_osc_enable_i = 1, fast_osc_idle_keep_i = 0, slow_osc_idle_keep_i = 0;
    logic [2:0] sys_clk_select_i = 0;
    wire        cpu_clk_en_o, sys_clk_en_o, fast_clk_en_o, slow_clk_en_o, slow_rc_clk_en_o;
    wire        fast_osc_run_o, slow_osc_run_o, fast_osc_stable_flag_o;
    wire  [2:0] active_select_o, op_mode_o;
    int         mismatches = 0, n_checks = 0;
    scm_sysclk_ctrl #(.FAST_STAB_CYC(16)) u_dut (.*);
    always #4 mclk_i = ~mclk_i;
    task report_and_stop;
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    // one-cycle pulse on halt (h=1) or wake (h=0), then settle two cycles
    task pulse(input bit h);
        halt_i = h;
        wake_i = !h;
        cyc(1);
        halt_i = 0;
        wake_i = 0;
        cyc(2);
    endtask
    // switch-over waits for oscillator stability, and for a tick boundary when moving to a fast code
    task wait_sel(input logic [2:0] v);
        int i;
        sys_clk_select_i = v;
        for (i = 0; i < 9000 && active_select_o !== v; i++) cyc(1);
        if (i == 9000)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task period(output int p);
        int i;
        for (i = 0; i < 9000 && cpu_clk_en_o !== 1'b1; i++) cyc(1);
        p = 0;
        do
        begin
            cyc(1);
            p++;
        end while (cpu_clk_en_o !== 1'b1 && p < 9000);
        if (i == 9000 || p == 9000)
        begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task t_modes;
        logic [2:0] em [4];
        em = '{`SCM_MODE_SLEEP, `SCM_MODE_IDLE_S, `SCM_MODE_IDLE_F, `SCM_MODE_IDLE_B};
        for (int k = 0; k < 4; k++)
        begin
            {fast_osc_idle_keep_i, slow_osc_idle_keep_i} = k[1:0];
            pulse(1);
            `CHK("mode", em[k], op_mode_o)
            `CHK("fast run", k[1], fast_osc_run_o)
            pulse(1);
            `CHK("halt ignored", em[k], op_mode_o)
            sys_clk_select_i = `SCM_SEL_SLOW;
            cyc(2);
            `CHK("select held", `SCM_SEL_DIV1, active_select_o)
            sys_clk_select_i = `SCM_SEL_DIV1;
            pulse(0);
            `CHK("woken", `SCM_MODE_FAST, op_mode_o)
        end
    endtask
    task t_wdt;
        {fast_osc_idle_keep_i, slow_osc_idle_keep_i} = 2'b00;
        for (int w = 0; w < 2; w++)
        begin
            wdt_enable_i = w[0];
            pulse(1);
            `CHK("slow rc", w[0], slow_osc_run_o)
            pulse(0);
        end
    endtask
    task t_stab;
        int i;
        wait_sel(`SCM_SEL_SLOW);
        fast_osc_enable_i = 0;
        cyc(2);
        `CHK("fast off", 1'b0, fast_osc_run_o)
        `CHK("flag low", 1'b0, fast_osc_stable_flag_o)
        fast_osc_enable_i = 1;
        cyc(2);
        `CHK("flag not yet", 1'b0, fast_osc_stable_flag_o)
        for (i = 0; i < 100 && fast_osc_stable_flag_o !== 1'b1; i++) cyc(1);
        if (i == 100)
        begin
            mismatches++;
            report_and_stop();
        end
        `CHK("flag set", 1'b1, fast_osc_stable_flag_o)
        wait_sel(`SCM_SEL_DIV1);
    endtask
    // every selector code, measured as the processor tick period
    task t_div;
        int p;
        int exp_p;
        for (int k = 0; k < 8; k++)
        begin
            wait_sel(k[2:0]);
            period(p);
            exp_p = (k == 7) ? 2 * `SCM_SLOW_HALF_CYC : (2 * `SCM_FAST_HALF_CYC) << k;
            `CHK("cpu period", exp_p, p)
        end
    endtask
    // single-oscillator idle modes, first with slow then with fast selected
    task t_idle;
        int cs, cc, cf, cl, cr;
        for (int k = 0; k < 4; k++)
        begin
            if (k == 2)
                wait_sel(`SCM_SEL_DIV1);
            {fast_osc_idle_keep_i, slow_osc_idle_keep_i} = k[0] ? 2'b10 : 2'b01;
            pulse(1);
            cs = 0;
            cc = 0;
            cf = 0;
            cl = 0;
            cr = 0;
            repeat (4000)
            begin
                cs += sys_clk_en_o;
                cc += cpu_clk_en_o;
                cf += fast_clk_en_o;
                cl += slow_clk_en_o;
                cr += slow_rc_clk_en_o;
                cyc(1);
            end
            `CHK("sys clk", k[0] == k[1], cs != 0)
            `CHK("cpu clk", 1'b0, cc != 0)
            `CHK("fast clk", k[0], cf != 0)
            `CHK("slow clk", !k[0], cl != 0)
            `CHK("slow rc clk", 1'b1, cr != 0)
            pulse(0);
        end
    endtask
    initial
    begin
        cyc(10);
        rst_i = 0;
        cyc(1);
        t_modes();
        t_wdt();
        t_stab();
        t_div();
        t_idle();
        report_and_stop();
    end
endmodule
